/* common/egd_pkg.sv */
package egd_pkg;

  // register byte addresses
  localparam logic [11:0] group_status_base = 12'hE00;
  localparam logic [11:0] affinity_low_addr = 12'hFA8;
  localparam logic [11:0] affinity_high_addr = 12'hFAC;
  localparam logic [11:0] arch_identity_addr = 12'hFBC;
  localparam logic [11:0] record_count_addr = 12'hFC8;
  localparam logic [11:0] ident_word0_addr = 12'hFF0;
  localparam logic [11:0] ident_word1_addr = 12'hFF4;
  localparam logic [11:0] ident_word2_addr = 12'hFF8;
  localparam logic [11:0] ident_word3_addr = 12'hFFC;

  // component identification constants
  localparam logic [7:0] preamble_byte_zero = 8'h0D;
  localparam logic [3:0] ident_class_generic = 4'hF;
  localparam logic [3:0] preamble_nibble_one = 4'h0;
  localparam logic [7:0] preamble_byte_two = 8'h05;
  localparam logic [7:0] preamble_byte_three = 8'hB1;

  // affinity valid markers and bit positions
  localparam logic [7:0] affinity_field_valid = 8'h80;
  localparam logic [7:0] affinity_field_invalid = 8'h00;
  localparam int lowest_valid_pos = 31;
  localparam int uniproc_pos = 30;
  localparam int threads_pos = 24;

  // architecture identity field positions and fixed values
  localparam int arch_present_pos = 20;
  localparam logic [3:0] architecture_revision = 4'h0;
  localparam logic [3:0] architecture_version = 4'h0;

  // unmapped addresses read zero
  localparam logic [31:0] unmapped_read_value = 32'h0000_0000;

  // affinity layout selector
  typedef enum logic [1:0]
  {
    egd_layout_level0,
    egd_layout_level1,
    egd_layout_level2,
    egd_layout_level3
  } egd_layout_type;

  // avalon request bundle
  typedef struct packed
  {
    logic [11:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } egd_req_type;

  // avalon answer bundle
  typedef struct packed
  {
    logic [31:0] readdata;
    logic waitrequest;
  } egd_rsp_type;

endpackage : egd_pkg

/* logic/egd_regs.sv */
`timescale 1ns/1ps

module egd_regs #(
  parameter int num_records = 64, // implemented error records
  parameter int num_status_words = 1, // 64-record status words
  parameter bit ident_present = 1'b1, // identification scheme built
  parameter bit affinity_present = 1'b1, // group tied to processors
  parameter bit arch_present = 1'b1, // architecture fields built
  parameter logic [10:0] designer_code = 11'h155, // arbitrary value
  parameter logic [11:0] architecture_code = 12'h5A5 // arbitrary value
)
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire egd_pkg::egd_req_type bus_req,
  output egd_pkg::egd_rsp_type bus_rsp,
  input wire logic [num_records-1:0] record_valid,
  input wire logic [1:0] affinity_layout,
  input wire logic [63:0] processor_affinity_source
);

  //////////////////////////////////////////////////////////////////////
  // affinity word assembly

  egd_pkg::egd_layout_type layout; // decoded layout selector
  logic [63:0] processor_affinity; // full 64-bit affinity view
  logic lowest_valid; // lowest level field usable
  assign layout = egd_pkg::egd_layout_type'(affinity_layout);

  // lowest field valid comes from the source copy
  assign lowest_valid = processor_affinity_source[egd_pkg::lowest_valid_pos];

  // marker bytes replace the affinity values per layout
  always_comb
  begin
    processor_affinity = 64'h0;
    if (affinity_present)
    begin
      // level3 value sits high, reserved stays zero
      processor_affinity[39:32] = processor_affinity_source[39:32];
      processor_affinity[31] = lowest_valid;
      // flags forced low when the lowest field is invalid
      processor_affinity[30] = lowest_valid &
        processor_affinity_source[egd_pkg::uniproc_pos];
      processor_affinity[24] = lowest_valid &
        processor_affinity_source[egd_pkg::threads_pos];
      processor_affinity[23:0] = processor_affinity_source[23:0];
      case (layout)
        egd_pkg::egd_layout_level0:
        begin
          // all three low bytes are plain values
          processor_affinity[7:0] = processor_affinity_source[7:0];
        end
        egd_pkg::egd_layout_level1:
        begin
          processor_affinity[7:0] = processor_affinity_source[7]
            ? egd_pkg::affinity_field_valid
            : egd_pkg::affinity_field_invalid;
        end
        egd_pkg::egd_layout_level2:
        begin
          processor_affinity[15:8] = processor_affinity_source[15]
            ? egd_pkg::affinity_field_valid
            : egd_pkg::affinity_field_invalid;
          processor_affinity[7:0] = processor_affinity_source[7]
            ? egd_pkg::affinity_field_valid
            : egd_pkg::affinity_field_invalid;
        end
        egd_pkg::egd_layout_level3:
        begin
          processor_affinity[23:16] = egd_pkg::affinity_field_valid;
          processor_affinity[15:8] = processor_affinity_source[15]
            ? egd_pkg::affinity_field_valid
            : egd_pkg::affinity_field_invalid;
          processor_affinity[7:0] = processor_affinity_source[7]
            ? egd_pkg::affinity_field_valid
            : egd_pkg::affinity_field_invalid;
        end
        default:
        begin
          processor_affinity = 64'h0;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // fixed identity words

  logic [31:0] architecture_identity; // architecture word
  logic [31:0] record_count; // highest index plus one
  logic [31:0] ident_word [4]; // component identification words

  // absent architecture fields leave only zeros
  always_comb
  begin
    architecture_identity = 32'h0;
    if (arch_present)
    begin
      architecture_identity[31:21] = designer_code;
      architecture_identity[egd_pkg::arch_present_pos] = 1'b1;
      architecture_identity[19:16] =
        egd_pkg::architecture_revision;
      architecture_identity[15:12] =
        egd_pkg::architecture_version;
      architecture_identity[11:0] = architecture_code;
    end
  end

  assign record_count = {16'h0, 16'(num_records)};

  // identification words read zero when not built
  always_comb
  begin
    ident_word[0] = 32'h0;
    ident_word[1] = 32'h0;
    ident_word[2] = 32'h0;
    ident_word[3] = 32'h0;
    if (ident_present)
    begin
      ident_word[0] = {24'h0, egd_pkg::preamble_byte_zero};
      ident_word[1] = {24'h0, egd_pkg::ident_class_generic,
                       egd_pkg::preamble_nibble_one};
      ident_word[2] = {24'h0, egd_pkg::preamble_byte_two};
      ident_word[3] = {24'h0, egd_pkg::preamble_byte_three};
    end
  end

  //////////////////////////////////////////////////////////////////////
  // group status array

  localparam int status_bits = num_status_words * 64;
  logic [status_bits-1:0] status_flat; // zero-padded valid flags

  // records beyond the implemented count read zero
  always_comb
  begin
    status_flat = '0;
    for (int i = 0; i < num_records && i < status_bits; i++)
    begin
      status_flat[i] = record_valid[i];
    end
  end

  //////////////////////////////////////////////////////////////////////
  // read decode

  logic [31:0] next_readdata; // value for the addressed word
  logic [11:0] status_offset; // offset into the status array
  logic [8:0] status_half; // 32-bit half index into array
  assign status_offset = bus_req.address - egd_pkg::group_status_base;
  assign status_half = status_offset[10:2];

  // whole-word decode; byte lanes are not split on read
  always_comb
  begin
    next_readdata = egd_pkg::unmapped_read_value;
    if (bus_req.address >= egd_pkg::group_status_base &&
        int'(status_offset) < num_status_words * 8)
    begin
      // low half at +0, high half at +4 of each 8-byte word
      next_readdata = status_flat[32*status_half +: 32];
    end
    else
    begin
      case (bus_req.address)
        egd_pkg::affinity_low_addr:
          next_readdata = processor_affinity[31:0];
        egd_pkg::affinity_high_addr:
          next_readdata = processor_affinity[63:32];
        egd_pkg::arch_identity_addr:
          next_readdata = architecture_identity;
        egd_pkg::record_count_addr:
          next_readdata = record_count;
        egd_pkg::ident_word0_addr:
          next_readdata = ident_word[0];
        egd_pkg::ident_word1_addr:
          next_readdata = ident_word[1];
        egd_pkg::ident_word2_addr:
          next_readdata = ident_word[2];
        egd_pkg::ident_word3_addr:
          next_readdata = ident_word[3];
        default:
          next_readdata = egd_pkg::unmapped_read_value;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // avalon slave: one wait cycle so readdata comes from a flop

  logic ack; // answer phase of the current request
  logic [31:0] readdata; // registered read answer

  // ack rises one cycle after a request, then drops
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ack <= 1'b0;
    end
    else
    begin
      // writes complete like reads but store nothing
      ack <= (bus_req.read | bus_req.write) & ~ack;
    end
  end

  // capture read data while the request waits
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      readdata <= 32'h0;
    end
    else if (bus_req.read && !ack)
    begin
      readdata <= next_readdata;
    end
  end

  assign bus_rsp.readdata = readdata;
  assign bus_rsp.waitrequest = (bus_req.read | bus_req.write) & ~ack;

  //////////////////////////////////////////////////////////////////////
  // checks

  a_ident_preamble: assert property (@(posedge sys_clk) disable iff (!rst_n)
    bus_req.read && !ack && bus_req.address == egd_pkg::ident_word0_addr
    |=> bus_rsp.readdata == (ident_present ? 32'h0000_000D : 32'h0))
    else $error("ident word0 wrong");

  a_ident_class: assert property (@(posedge sys_clk) disable iff (!rst_n)
    bus_req.read && !ack && bus_req.address == egd_pkg::ident_word1_addr
    |=> bus_rsp.readdata == (ident_present ? 32'h0000_00F0 : 32'h0))
    else $error("ident word1 wrong");

  a_ident_word3: assert property (@(posedge sys_clk) disable iff (!rst_n)
    bus_req.read && !ack && bus_req.address == egd_pkg::ident_word3_addr
    |=> bus_rsp.readdata == (ident_present ? 32'h0000_00B1 : 32'h0))
    else $error("ident word3 wrong");

  a_arch_present: assert property (@(posedge sys_clk) disable iff (!rst_n)
    bus_req.read && !ack && bus_req.address == egd_pkg::arch_identity_addr
    |=> bus_rsp.readdata[20] == arch_present &&
        bus_rsp.readdata[19:12] == 8'h00)
    else $error("architecture word wrong");

  a_count_value: assert property (@(posedge sys_clk) disable iff (!rst_n)
    bus_req.read && !ack && bus_req.address == egd_pkg::record_count_addr
    |=> bus_rsp.readdata == 32'(num_records))
    else $error("record count wrong");

  a_aff_reserved: assert property (@(posedge sys_clk) disable iff (!rst_n)
    processor_affinity[63:40] == 24'h0 &&
    processor_affinity[29:25] == 5'h0)
    else $error("affinity reserved bits set");

  a_aff_level3: assert property (@(posedge sys_clk) disable iff (!rst_n)
    affinity_present && layout == egd_pkg::egd_layout_level3
    |-> processor_affinity[23:16] == 8'h80)
    else $error("level3 marker wrong");

  a_status_mirror: assert property (@(posedge sys_clk) disable iff (!rst_n)
    bus_req.read && !ack && bus_req.address == egd_pkg::group_status_base
    |=> bus_rsp.readdata[0] == $past(record_valid[0]))
    else $error("status bit mismatch");

  a_wait_once: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (bus_req.read | bus_req.write) && !ack
    |-> bus_rsp.waitrequest ##1 !bus_rsp.waitrequest)
    else $error("answer not one cycle later");

  c_read_ident: cover property (@(posedge sys_clk) disable iff (!rst_n)
    bus_req.read && ack && bus_req.address == egd_pkg::ident_word0_addr);
  c_read_status: cover property (@(posedge sys_clk) disable iff (!rst_n)
    bus_req.read && ack && bus_req.address == egd_pkg::group_status_base);
  c_write_ignored: cover property (@(posedge sys_clk) disable iff (!rst_n)
    bus_req.write && ack);

endmodule : egd_regs

/* bench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  ////////////////////////////////////////////////////////////////////////
  // arbitrary identity values handed to the design
  localparam logic [10:0] dcode = 11'h2AA; // arbitrary value
  localparam logic [11:0] acode = 12'h3C3; // arbitrary value
  localparam int nrec = 40; // fewer records so upper status bits read zero
  logic sys_clk;
  logic rst_n;
  egd_pkg::egd_req_type bus_req;
  egd_pkg::egd_rsp_type bus_rsp;
  logic [nrec-1:0] record_valid;
  logic [1:0] affinity_layout;
  logic [63:0] processor_affinity_source;
  int mismatches;
  int n_tests;
  int cycles = 0;
  logic [31:0] seed;
  logic [31:0] rd;
  logic [63:0] src;
  logic [nrec-1:0] rv;
  logic [127:0] exp_dyn; // status word above affinity word
  logic [11:0] fixed_addr [7];
  logic [31:0] fixed_val [7];

  egd_regs #(.num_records(nrec), .num_status_words(1),
    .designer_code(dcode), .architecture_code(acode)) egd_regs_i (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .bus_req(bus_req),
    .bus_rsp(bus_rsp),
    .record_valid(record_valid),
    .affinity_layout(affinity_layout),
    .processor_affinity_source(processor_affinity_source)
  );

  ////////////////////////////////////////////////////////////////////////
  // free-running 125 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // hang guard: the whole run needs far fewer cycles
  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      mismatches = mismatches + 1;
      test_done();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // next pseudo-random word, fixed seed keeps runs repeatable
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // affinity expected for a layout; flags masked when lowest invalid
  function automatic logic [63:0] exp_aff(input logic [1:0] lay,
    input logic [63:0] s);
    logic [63:0] e;
    e = 64'h0;
    e[39:32] = s[39:32];
    e[31] = s[31];
    e[30] = s[31] & s[30];
    e[24] = s[31] & s[24];
    e[23:0] = s[23:0];
    if (lay == 2'h3)
      e[23:16] = 8'h80;
    if (lay >= 2'h2)
      e[15:8] = s[15] ? 8'h80 : 8'h00;
    if (lay >= 2'h1)
      e[7:0] = s[7] ? 8'h80 : 8'h00;
    return e;
  endfunction : exp_aff

  // one avalon transfer; request held until waitrequest sampled low
  task automatic bus(input logic [11:0] a, input logic wr,
    input logic [31:0] wd, output logic [31:0] r);
    @(posedge sys_clk);
    bus_req.address <= a;
    bus_req.read <= ~wr;
    bus_req.write <= wr;
    bus_req.writedata <= wd;
    bus_req.byteenable <= 4'hF;
    @(posedge sys_clk);
    while (bus_rsp.waitrequest !== 1'b0)
      @(posedge sys_clk);
    r = bus_rsp.readdata;
    bus_req.read <= 1'b0;
    bus_req.write <= 1'b0;
  endtask : bus

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests = n_tests + 1;
    if (seen !== exp)
    begin
      mismatches = mismatches + 1;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic test_done;
    $display("comparisons=%0d mismatches=%0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : test_done

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    mismatches = 0;
    n_tests = 0;
    rst_n = 1'b0;
    bus_req = '0;
    record_valid = '0;
    affinity_layout = 2'h0;
    processor_affinity_source = 64'h0;
    seed = 32'h430D4D78;
    fixed_addr = '{egd_pkg::ident_word0_addr, egd_pkg::ident_word1_addr,
      egd_pkg::ident_word2_addr, egd_pkg::ident_word3_addr,
      egd_pkg::arch_identity_addr, egd_pkg::record_count_addr, 12'h004};
    fixed_val = '{32'h0000000D, 32'h000000F0, 32'h00000005, 32'h000000B1,
      {dcode, 1'b1, 4'h0, 4'h0, acode}, 32'h00000028, 32'h00000000};
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    // constant words: plain, after stray writes, after a second reset
    for (int p = 0; p < 3; p++)
    begin
      if (p == 2)
      begin
        @(posedge sys_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
      end
      for (int i = 0; i < 7; i++)
      begin
        seed = lfsr(seed);
        if (p == 1)
          bus(fixed_addr[i], 1'b1, seed, rd);
        bus(fixed_addr[i], 1'b0, 32'h0, rd);
        check(rd, fixed_val[i]);
      end
    end
    // affinity and status under random sources, all four layouts
    for (int k = 0; k < 48; k++)
    begin
      seed = lfsr(seed);
      src[31:0] = seed;
      seed = lfsr(seed);
      src[63:32] = seed;
      seed = lfsr(seed);
      rv = {seed[7:0], src[31:0] ^ seed};
      // corners: everything set, then every valid flag clear
      if (k == 0)
      begin
        src = '1;
        rv = '1;
      end
      if (k == 1)
      begin
        src = 64'hFFFF_FFFF_7FFF_7F7F;
        rv = '0;
      end
      @(posedge sys_clk);
      processor_affinity_source <= src;
      record_valid <= rv;
      affinity_layout <= k[1:0];
      exp_dyn = {24'h0, rv, exp_aff(k[1:0], src)};
      for (int j = 0; j < 4; j++)
      begin
        if (k[2])
          bus((j < 2 ? egd_pkg::affinity_low_addr : egd_pkg::group_status_base)
            + 12'(4 * (j % 2)), 1'b1, seed, rd);
        bus((j < 2 ? egd_pkg::affinity_low_addr : egd_pkg::group_status_base)
          + 12'(4 * (j % 2)), 1'b0, 32'h0, rd);
        check(rd, exp_dyn[32 * j +: 32]);
      end
    end
    test_done();
  end
endmodule : tb_top
